// ===== inc/cpw_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the pwm unit
// Assumes: byte-wide register port with a 3-bit address
// Notes:   definitions only
`ifndef CPW_DEFS_SVH
`define CPW_DEFS_SVH

// ============================================================
// register offsets
`define CPW_OFF_UNIT_CONTROL   3'h0
`define CPW_OFF_DUTY_HIGH      3'h1
`define CPW_OFF_DUTY_SHADOW    3'h2
`define CPW_OFF_PERIOD_LIMIT   3'h3
`define CPW_OFF_TIMER_CONTROL  3'h4
`define CPW_OFF_PERIOD_TIMER   3'h5
`define CPW_OFF_PORT_CONFIG    3'h6

// ============================================================
// unit_control fields
`define CPW_CTL_LOW_HI         5
`define CPW_CTL_LOW_LO         4
`define CPW_CTL_MODE_HI        3
`define CPW_CTL_MODE_PWM_LO    2
`define CPW_MODE_PWM           2'h3

// ============================================================
// period_timer_control fields
`define CPW_TCT_POST_HI        6
`define CPW_TCT_POST_LO        3
`define CPW_TCT_ON             2
`define CPW_TCT_PRE_HI         1
`define CPW_TCT_PRE_LO         0

// ============================================================
// port_config fields
`define CPW_PRT_LATCH_DEF      0
`define CPW_PRT_LATCH_ALT      1
`define CPW_PRT_DIR_DEF        2
`define CPW_PRT_DIR_ALT        3
`define CPW_PRT_PIN_SEL        4

// ============================================================
// reset values
`define CPW_RST_UNIT_CONTROL   6'h00
`define CPW_RST_DUTY           8'h00
`define CPW_RST_PERIOD_LIMIT   8'hFF
`define CPW_RST_TIMER_CONTROL  7'h00
`define CPW_RST_PERIOD_TIMER   8'h00
`define CPW_RST_PORT_CONFIG    5'h0C

// ============================================================
// timing: oscillator periods per instruction cycle, prescale terminal counts
`define CPW_OSC_PER_CYCLE      4
`define CPW_PRE_LAST_1         4'h0
`define CPW_PRE_LAST_4         4'h3
`define CPW_PRE_LAST_16        4'hF

`endif

// ===== inc/cpw_pkg.sv
// Purpose: shared types of the pwm unit
// Assumes: nothing
// Notes:   constants live in cpw_defs.svh
package cpw_pkg;

  // ============================================================
  // types
  typedef logic [7:0] cpw_byte_t;
  typedef logic [9:0] cpw_base_t;
  typedef logic [2:0] cpw_addr_t;

endpackage

// ===== verilog/cpw_pwm_unit.sv
// Purpose: pwm mode of a capture/compare/pwm unit with its period timer
// Assumes: ref_clk is the system oscillator; sleep_mode comes from ref_clk logic
// Notes:   capture and compare actions are not built; the compare latch stays low
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpw_defs.svh"

module cpw_pwm_unit
  import cpw_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire logic      sleep_mode,
  input  wire cpw_addr_t reg_addr,
  input  wire cpw_byte_t reg_wdata,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  output cpw_byte_t      reg_rdata,
  output logic           pin_def_out,
  output logic           pin_def_oe_n,
  output logic           pin_alt_out,
  output logic           pin_alt_oe_n
);

  // ============================================================
  // functions
  function automatic logic is_pwm(input logic [5:0] ctl);
    is_pwm = (ctl[`CPW_CTL_MODE_HI:`CPW_CTL_MODE_PWM_LO] == `CPW_MODE_PWM);
  endfunction

  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    pre_last = (sel == 2'h0) ? `CPW_PRE_LAST_1 :
               (sel == 2'h1) ? `CPW_PRE_LAST_4 : `CPW_PRE_LAST_16;
  endfunction

  // ============================================================
  // state
  logic [5:0] ctl_ff;
  cpw_byte_t  duty_hi_ff;
  cpw_byte_t  shadow_ff;
  logic [1:0] lat2_ff;
  cpw_byte_t  limit_ff;
  logic [6:0] tctl_ff;
  cpw_byte_t  tmr_ff;
  logic [1:0] phase_ff;
  logic [3:0] pre_ff;
  logic       level_ff;
  logic [4:0] port_ff;
  cpw_byte_t  rdata_ff;
  logic       def_out_ff;
  logic       def_oe_n_ff;
  logic       alt_out_ff;
  logic       alt_oe_n_ff;

  // ============================================================
  // decode
  wire wr_ctl    = reg_wr && (reg_addr == `CPW_OFF_UNIT_CONTROL);
  wire wr_duty   = reg_wr && (reg_addr == `CPW_OFF_DUTY_HIGH);
  wire wr_shadow = reg_wr && (reg_addr == `CPW_OFF_DUTY_SHADOW);
  wire wr_limit  = reg_wr && (reg_addr == `CPW_OFF_PERIOD_LIMIT);
  wire wr_tctl   = reg_wr && (reg_addr == `CPW_OFF_TIMER_CONTROL);
  wire wr_tmr    = reg_wr && (reg_addr == `CPW_OFF_PERIOD_TIMER);
  wire wr_port   = reg_wr && (reg_addr == `CPW_OFF_PORT_CONFIG);

  wire       pwm_on  = is_pwm(ctl_ff);
  // oscillator stopped in sleep: nothing below advances
  wire       run     = !sleep_mode;
  wire [1:0] pre_sel = tctl_ff[`CPW_TCT_PRE_HI:`CPW_TCT_PRE_LO];
  wire       tmr_on  = tctl_ff[`CPW_TCT_ON];
  wire       cyc_end = run && (phase_ff == 2'(`CPW_OSC_PER_CYCLE - 1));
  wire       pre_end = (pre_ff == pre_last(pre_sel));
  // postscaler bits never reach the increment path
  wire       tmr_inc = cyc_end && tmr_on && pre_end;
  wire       restart = tmr_inc && (tmr_ff == limit_ff);
  wire [1:0] low_now = ctl_ff[`CPW_CTL_LOW_HI:`CPW_CTL_LOW_LO];
  wire [9:0] duty_new = {duty_hi_ff, low_now};
  wire [1:0] base_lo = (pre_sel == 2'h0) ? phase_ff :
                       (pre_sel == 2'h1) ? pre_ff[1:0] : pre_ff[3:2];
  wire cpw_base_t time_base = {tmr_ff, base_lo};
  // duty above the period never equals the base, so no clear
  wire       match   = pwm_on && run && tmr_on &&
                       (time_base == {shadow_ff, lat2_ff});
  // clear acts in the match cycle, so high time equals the duty count
  wire       pwm_high = level_ff && !match;
  wire       owned   = (ctl_ff != 6'h00);
  wire       pin_sel = port_ff[`CPW_PRT_PIN_SEL];

  wire nxt_level = !pwm_on ? 1'b0 :
                   restart ? (duty_new != 10'h000) :
                   match   ? 1'b0 : level_ff;
  wire nxt_def_out = (owned && !pin_sel) ? pwm_high : port_ff[`CPW_PRT_LATCH_DEF];
  wire nxt_alt_out = (owned && pin_sel) ? pwm_high : port_ff[`CPW_PRT_LATCH_ALT];

  cpw_byte_t nxt_rdata;
  always_comb begin
    unique case (reg_addr)
      `CPW_OFF_UNIT_CONTROL:  nxt_rdata = {2'h0, ctl_ff};
      `CPW_OFF_DUTY_HIGH:     nxt_rdata = duty_hi_ff;
      `CPW_OFF_DUTY_SHADOW:   nxt_rdata = shadow_ff;
      `CPW_OFF_PERIOD_LIMIT:  nxt_rdata = limit_ff;
      `CPW_OFF_TIMER_CONTROL: nxt_rdata = {1'b0, tctl_ff};
      `CPW_OFF_PERIOD_TIMER:  nxt_rdata = tmr_ff;
      `CPW_OFF_PORT_CONFIG:   nxt_rdata = {3'h0, port_ff};
      default:                nxt_rdata = 8'h00;
    endcase
  end

  // ============================================================
  // software registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_ff     <= `CPW_RST_UNIT_CONTROL;
      duty_hi_ff <= `CPW_RST_DUTY;
      limit_ff   <= `CPW_RST_PERIOD_LIMIT;
      tctl_ff    <= `CPW_RST_TIMER_CONTROL;
      port_ff    <= `CPW_RST_PORT_CONFIG;
    end else begin
      // taken any time; duty_hi_ff and the low duty bits are seen only at the next restart
      if (wr_ctl)   ctl_ff     <= reg_wdata[5:0];
      if (wr_duty)  duty_hi_ff <= reg_wdata;
      if (wr_limit) limit_ff   <= reg_wdata;
      if (wr_tctl)  tctl_ff    <= reg_wdata[6:0];
      if (wr_port)  port_ff    <= reg_wdata[4:0];
    end
  end

  // ============================================================
  // time base
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= 2'h0;
      pre_ff   <= 4'h0;
      tmr_ff   <= `CPW_RST_PERIOD_TIMER;
    end else begin
      if (run) phase_ff <= phase_ff + 2'h1;
      if (cyc_end && tmr_on) pre_ff <= pre_end ? 4'h0 : pre_ff + 4'h1;
      if (wr_tmr) tmr_ff <= reg_wdata;
      else if (restart) tmr_ff <= 8'h00;
      else if (tmr_inc) tmr_ff <= tmr_ff + 8'h01;
    end
  end

  // ============================================================
  // duty buffer and output latch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shadow_ff <= `CPW_RST_DUTY;
      lat2_ff   <= 2'h0;
      level_ff  <= 1'b0;
    end else begin
      // restart wins over a software write in the same cycle
      if (restart) begin
        shadow_ff <= duty_hi_ff;
        lat2_ff   <= low_now;
      end else if (wr_shadow && !pwm_on) begin
        shadow_ff <= reg_wdata;
      end
      level_ff <= nxt_level;
    end
  end

  // ============================================================
  // pins and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      def_out_ff  <= 1'b0;
      def_oe_n_ff <= 1'b1;
      alt_out_ff  <= 1'b0;
      alt_oe_n_ff <= 1'b1;
      rdata_ff    <= 8'h00;
    end else begin
      def_out_ff  <= nxt_def_out;
      def_oe_n_ff <= port_ff[`CPW_PRT_DIR_DEF];
      alt_out_ff  <= nxt_alt_out;
      alt_oe_n_ff <= port_ff[`CPW_PRT_DIR_ALT];
      rdata_ff    <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign pin_def_out  = def_out_ff;
  assign pin_def_oe_n = def_oe_n_ff;
  assign pin_alt_out  = alt_out_ff;
  assign pin_alt_oe_n = alt_oe_n_ff;

  // ============================================================
  // assertions
  property p_wrap;
    @(posedge ref_clk) disable iff (rst)
      restart && !wr_tmr |=> (tmr_ff == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer did not clear at limit");

  property p_inc;
    @(posedge ref_clk) disable iff (rst)
      tmr_inc && !restart && !wr_tmr |=> (tmr_ff == $past(tmr_ff) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("timer did not step");

  property p_copy;
    @(posedge ref_clk) disable iff (rst)
      restart |=> (shadow_ff == $past(duty_hi_ff)) && (lat2_ff == $past(low_now));
  endproperty
  a_copy: assert property (p_copy) else $error("duty not buffered at restart");

  property p_set;
    @(posedge ref_clk) disable iff (rst)
      restart && !wr_tmr && pwm_on && (duty_new != 10'h000) |=>
        level_ff ##1 (def_out_ff || pin_sel || !owned);
  endproperty
  a_set: assert property (p_set) else $error("pin not set at restart");

  property p_zero;
    @(posedge ref_clk) disable iff (rst)
      restart && (duty_new == 10'h000) |=> !level_ff;
  endproperty
  a_zero: assert property (p_zero) else $error("zero duty set the pin");

  property p_clear;
    @(posedge ref_clk) disable iff (rst)
      match && !restart |=> !level_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("match did not clear");

  property p_sleep;
    @(posedge ref_clk) disable iff (rst)
      sleep_mode && !reg_wr |=> $stable(tmr_ff) && $stable(level_ff) && $stable(phase_ff);
  endproperty
  a_sleep: assert property (p_sleep) else $error("state moved in sleep");

  property p_ro;
    @(posedge ref_clk) disable iff (rst)
      wr_shadow && pwm_on && !restart |=> $stable(shadow_ff);
  endproperty
  a_ro: assert property (p_ro) else $error("shadow written in pwm mode");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
      !restart && !wr_shadow |=> $stable(shadow_ff) && $stable(lat2_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("duty write leaked early");

  property p_release;
    @(posedge ref_clk) disable iff (rst)
      (ctl_ff == 6'h00) |=> (def_out_ff == $past(port_ff[`CPW_PRT_LATCH_DEF]));
  endproperty
  a_release: assert property (p_release) else $error("pin not returned to port");

  property p_route;
    @(posedge ref_clk) disable iff (rst)
      owned && pin_sel |=> (alt_out_ff == $past(pwm_high));
  endproperty
  a_route: assert property (p_route) else $error("alternate pin not routed");

  property p_dir;
    @(posedge ref_clk) disable iff (rst)
      port_ff[`CPW_PRT_DIR_DEF] |=> def_oe_n_ff;
  endproperty
  a_dir: assert property (p_dir) else $error("input pin was driven");

  property p_alt_dir;
    @(posedge ref_clk) disable iff (rst)
      port_ff[`CPW_PRT_DIR_ALT] |=> alt_oe_n_ff;
  endproperty
  a_alt_dir: assert property (p_alt_dir) else $error("alternate input pin driven");

  property p_phase;
    @(posedge ref_clk) disable iff (rst)
      run |=> (phase_ff == 2'($past(phase_ff) + 2'h1));
  endproperty
  a_phase: assert property (p_phase) else $error("oscillator phase did not step");

  property p_over;
    @(posedge ref_clk) disable iff (rst)
      pwm_on && level_ff && !restart && (tmr_ff <= limit_ff) &&
      ({shadow_ff, lat2_ff} > {limit_ff, 2'h3}) |=> level_ff;
  endproperty
  a_over: assert property (p_over) else $error("long duty cleared the pin");

  property p_sleep_pin;
    @(posedge ref_clk) disable iff (rst)
      sleep_mode && $past(sleep_mode) && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2)
        |=> $stable(def_out_ff) && $stable(alt_out_ff);
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("pin moved in sleep");

endmodule // cpw_pwm_unit
`default_nettype wire

// ===== tb/cpw_pin_load.sv
// Purpose: load on the two pwm pads; counts high cycles and edge spacing
// Assumes: no pull on either pad line
// Notes:   high-cycle counts clear when meas_en rises and hold once it falls; last_period ignores meas_en
`timescale 1ns/1ps
`default_nettype none

module cpw_pin_load (
  input  wire logic        ref_clk,
  input  wire logic        pin_def_out,
  input  wire logic        pin_def_oe_n,
  input  wire logic        pin_alt_out,
  input  wire logic        pin_alt_oe_n,
  input  wire logic        meas_en,
  output logic             pad_def,
  output logic             pad_alt,
  output logic [31:0]      hi_def,
  output logic [31:0]      hi_alt,
  output logic [31:0]      last_period
);
  // ==========================================================
  // pads: a released line shows the inverse of its last level
  logic        last_def = 1'b0;
  logic        last_alt = 1'b0;
  logic        meas_q   = 1'b0;
  logic        prev_def = 1'b0;
  logic [31:0] since    = '0;
  assign pad_def = (pin_def_oe_n === 1'b0) ? pin_def_out : ~last_def;
  assign pad_alt = (pin_alt_oe_n === 1'b0) ? pin_alt_out : ~last_alt;

  // ==========================================================
  // measurement
  always @(posedge ref_clk) begin
    if (pin_def_oe_n === 1'b0) last_def <= pin_def_out;
    if (pin_alt_oe_n === 1'b0) last_alt <= pin_alt_out;
    prev_def <= pad_def;
    meas_q   <= meas_en;
    if (meas_en) begin
      hi_def <= (meas_q ? hi_def : 32'h0) + 32'(pad_def);
      hi_alt <= (meas_q ? hi_alt : 32'h0) + 32'(pad_alt);
    end
    since <= (pad_def && !prev_def) ? 32'h1 : since + 32'h1;
    if (pad_def && !prev_def) begin
      last_period <= since;
    end
  end
endmodule // cpw_pin_load

`default_nettype wire

// ===== tb/test_ccp_pwm_mode_unit.sv
// Purpose: self-checking bench of the pwm unit
// Assumes: offsets and reset values of cpw_defs.svh
// Notes:   windows span two whole periods, so phase does not matter
`timescale 1ns/1ps
`default_nettype none
`include "cpw_defs.svh"

module test_ccp_pwm_mode_unit;
  import cpw_pkg::*;
  typedef struct packed {
    logic [7:0]  lim;
    logic [1:0]  pre;
    logic [9:0]  duty;
    logic [15:0] hi;
    logic [15:0] per;
  } cpw_row_s;
  logic        ref_clk, rst, sleep_mode, reg_wr, reg_rd, meas_en;
  cpw_addr_t   reg_addr;
  cpw_byte_t   reg_wdata, reg_rdata, va, vb;
  logic        pin_def_out, pin_def_oe_n, pin_alt_out, pin_alt_oe_n, pad_def, pad_alt;
  logic [31:0] hi_def, hi_alt, last_period;
  int          fails, checks_done;
  // hi and per are ref_clk cycles of one period at the row's prescale ratio
  cpw_row_s    rows [8] = '{
    '{8'h00, 2'h0, 10'h002, 16'h0002, 16'h0004}, '{8'h03, 2'h0, 10'h005, 16'h0005, 16'h0010},
    '{8'h02, 2'h0, 10'h000, 16'h0000, 16'h000C}, '{8'h01, 2'h0, 10'h009, 16'h0008, 16'h0008},
    '{8'h01, 2'h1, 10'h003, 16'h000C, 16'h0020}, '{8'h00, 2'h3, 10'h001, 16'h0010, 16'h0040},
    '{8'h00, 2'h2, 10'h003, 16'h0030, 16'h0040}, '{8'hFF, 2'h0, 10'h3E8, 16'h03E8, 16'h0400}};
  cpw_byte_t   rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h0C, 8'h00};

  cpw_pwm_unit DUT (.ref_clk(ref_clk), .rst(rst), .sleep_mode(sleep_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_def_out(pin_def_out), .pin_def_oe_n(pin_def_oe_n),
    .pin_alt_out(pin_alt_out), .pin_alt_oe_n(pin_alt_oe_n));
  cpw_pin_load u_load (.ref_clk(ref_clk), .pin_def_out(pin_def_out),
    .pin_def_oe_n(pin_def_oe_n), .pin_alt_out(pin_alt_out), .pin_alt_oe_n(pin_alt_oe_n),
    .meas_en(meas_en), .pad_def(pad_def), .pad_alt(pad_alt), .hi_def(hi_def),
    .hi_alt(hi_alt), .last_period(last_period));

  // ==========================================================
  // clock, bus and compare tasks
  always #5 ref_clk = ~ref_clk;

  task automatic wr(input cpw_addr_t a, input cpw_byte_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // one idle edge after each strobe so no strobe is set twice in a step
  task automatic rd(input cpw_addr_t a, output cpw_byte_t q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    q = reg_rdata;
  endtask

  task automatic chk_byte(input cpw_byte_t got, input cpw_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    chk_byte(8'(got >> 16), 8'(exp >> 16));
    chk_byte(8'(got >> 8), 8'(exp >> 8));
    chk_byte(8'(got), 8'(exp));
  endtask

  task automatic measure(input int n);
    meas_en <= 1'b1;
    repeat (n) @(posedge ref_clk);
    meas_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: sequence needs about 11.5k cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial begin
    ref_clk = 1'b0; rst = 1'b1; sleep_mode = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = '0; reg_wdata = '0; meas_en = 1'b0; fails = 0; checks_done = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    wr(`CPW_OFF_PORT_CONFIG, 8'h08);
    foreach (rows[i]) begin
      wr(`CPW_OFF_TIMER_CONTROL, 8'h00);
      wr(`CPW_OFF_PERIOD_TIMER, 8'h00);
      wr(`CPW_OFF_PERIOD_LIMIT, rows[i].lim);
      wr(`CPW_OFF_DUTY_HIGH, rows[i].duty[9:2]);
      wr(`CPW_OFF_UNIT_CONTROL, {2'h0, rows[i].duty[1:0], 4'hC});
      // postscale field set to all ones; it must not move the period
      wr(`CPW_OFF_TIMER_CONTROL, {5'h1F, rows[i].pre});
      repeat (3 * rows[i].per) @(posedge ref_clk);
      measure(2 * rows[i].per);
      chk_cnt(hi_def, 32'(rows[i].hi) * 2);
      if (rows[i].hi != 0 && rows[i].hi != rows[i].per)
        chk_cnt(last_period, 32'(rows[i].per));
    end
    // duty writes wait for a restart; shadow ignores writes in pwm mode
    wr(`CPW_OFF_TIMER_CONTROL, 8'h00);
    wr(`CPW_OFF_DUTY_HIGH, 8'h40);
    wr(`CPW_OFF_DUTY_SHADOW, 8'h11);
    rd(`CPW_OFF_DUTY_SHADOW, va);
    chk_byte(va, 8'hFA);
    wr(`CPW_OFF_TIMER_CONTROL, 8'h04);
    repeat (1100) @(posedge ref_clk);
    rd(`CPW_OFF_DUTY_SHADOW, va);
    chk_byte(va, 8'h40);
    measure(2048);
    chk_cnt(hi_def, 32'h200);
    // sleep holds the count, wake resumes it
    sleep_mode <= 1'b1;
    @(posedge ref_clk);
    rd(`CPW_OFF_PERIOD_TIMER, va);
    repeat (20) @(posedge ref_clk);
    rd(`CPW_OFF_PERIOD_TIMER, vb);
    chk_byte(vb, va);
    sleep_mode <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(`CPW_OFF_PERIOD_TIMER, va);
    // eight awake cycles at 1:1 are exactly two timer steps
    chk_byte(va, vb + 8'h02);
    wr(`CPW_OFF_PORT_CONFIG, 8'h14);
    repeat (4) @(posedge ref_clk);
    measure(2048);
    chk_cnt(hi_alt, 32'h200);
    chk_byte(8'(pin_def_oe_n), 8'h01);
    wr(`CPW_OFF_UNIT_CONTROL, 8'h00);
    wr(`CPW_OFF_PORT_CONFIG, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk_byte(8'({pin_def_oe_n, pin_def_out}), 8'h01);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    chk_byte(8'({pin_def_oe_n, pin_alt_oe_n}), 8'h03);
    @(posedge ref_clk);
    wr(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(cpw_addr_t'(a), va);
      chk_byte(va, rst_exp[a]);
    end
    report_and_stop();
  end
endmodule // test_ccp_pwm_mode_unit

`default_nettype wire
